// >>> verilog/prbs_defines.svh
// Purpose: constants for the pattern test generator and checker
// Assumes: apb byte addresses, 32-bit data words
// Notes: offsets below are word aligned
`ifndef PRBS_DEFINES_SVH
`define PRBS_DEFINES_SVH
`define PRBS_OFF_MODE     12'h0000
`define PRBS_OFF_TXSEL    12'h0004
`define PRBS_OFF_RXSEL    12'h0008
`define PRBS_OFF_STAT     12'h000C
`define PRBS_OFF_ERRCNT   12'h0010
`define PRBS_OFF_IRQSTAT  12'h0014
`define PRBS_OFF_IRQMASK  12'h0018
`define PRBS_OFF_OUTCFG   12'h001C
`define PRBS_OFF_EBITCNT  12'h0020
`define PRBS_TXMODE_LSB   2
`define PRBS_RXMODE_LSB   0
`define PRBS_LFSR_W       15
`define PRBS_SLOT_W       5
`define PRBS_WIN_BITS     64
`define PRBS_ERR_LIMIT    6
`define PRBS_LOCK_GOOD    15
`define PRBS_SEED         15'h7FFF
`define PRBS_IRQ_W        3
`endif

// >>> verilog/prbs_pkg.sv
// Purpose: types for the pattern test block
// Assumes: nothing
// Notes: mode codes follow the two-bit select fields
package prbs_pkg;
   typedef enum logic [1:0] {
      PRBS_OFF    = 2'h0,
      PRBS_SLOT   = 2'h1,
      PRBS_FRAMED = 2'h2,
      PRBS_ALL    = 2'h3
   } prbs_mode_type;
   typedef enum {PRBS_HUNT, PRBS_VERIFY, PRBS_LOCKED} prbs_sync_type;
endpackage

// >>> verilog/prbs_lfsr.sv
// Purpose: one fifteen-stage pattern shift register
// Assumes: advance strobe is one cycle per pattern bit
// Notes: load shifts a received bit in place of the feedback bit when reseeding
`timescale 1ns/1ns
`default_nettype none
`include "prbs_defines.svh"
module prbs_lfsr (
   input  wire logic                    pclk,     // system clock
   input  wire logic                    presetn,  // async reset, low
   input  wire logic                    adv,      // shift one bit
   input  wire logic                    load,     // shift in given bit instead
   input  wire logic                    load_bit, // bit shifted in on load
   output logic                         fb,       // next pattern bit
   output logic [`PRBS_LFSR_W-1:0]      state     // current state
);
   logic [`PRBS_LFSR_W-1:0] state_r;
   assign fb    = state_r[14] ^ state_r[13];
   assign state = state_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= `PRBS_SEED;
      end else if (adv) begin
         state_r <= {state_r[13:0], load ? load_bit : fb};
      end
   end
endmodule
`default_nettype wire

// >>> verilog/prbs_slot_gate.sv
// Purpose: decides whether a frame bit belongs to the pattern
// Assumes: bit position 0..255 within the frame, slot = bit/8
// Notes: pure combinational select
`timescale 1ns/1ns
`default_nettype none
module prbs_slot_gate
   import prbs_pkg::*;
(
   input  wire logic [1:0] mode,     // pattern mode field
   input  wire logic [4:0] sel,      // selected slot
   input  wire logic [7:0] bitpos,   // bit position in frame
   output logic            use_bit   // bit carries pattern
);
   wire [4:0] slot      = bitpos[7:3];
   wire       is_sel    = (slot == sel);
   wire       not_align = (slot != 5'h00);
   assign use_bit = (mode == PRBS_SLOT)   ? is_sel :
                    (mode == PRBS_FRAMED) ? not_align :
                    (mode == PRBS_ALL)    ? 1'b1 : 1'b0;
endmodule
`default_nettype wire

// >>> verilog/prbs_test_top.sv
// Purpose: pattern generator and checker for one framer port, apb slave
// Assumes: tx/rx frame bit strobes and recovered clock come from pins
// Notes: one clock domain; line strobes are synchronised before use
// Overview of operation
// - generate the 2^15-1 pattern on transmit and check it on receive.
// - transmit mode field bits 3:2 pick off, one slot, slots 1-31 or all.
// - receive mode field bits 1:0 pick the same four choices for checking.
// - unframed mode fills all 256 frame bits including slot 0.
// - in transmit mode 01 the transmit slot select picks the pattern slot.
// - in receive mode 01 the receive slot select picks the checked slot.
// - the lock flag is bit 0 of the status register at offset 0x00C while locked.
// - lock drops after six or more errored bits inside a 64-bit window.
// - with receive mode not off the 16-bit error counter counts pattern errors.
// - either user output can be set to pulse once per pattern error.
// - the pulse is positive, aligned to the receive clock, only while locked.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "prbs_defines.svh"
module prbs_test_top
   import prbs_pkg::*;
(
   input  wire logic        pclk,          // system clock, 125 MHz
   input  wire logic        presetn,       // async reset, low
   input  wire logic        psel,          // apb select
   input  wire logic        penable,       // apb enable
   input  wire logic        pwrite,        // apb direction
   input  wire logic [11:0] paddr,         // apb byte address
   input  wire logic [31:0] pwdata,        // apb write data
   output logic             pready,        // apb ready
   output logic [31:0]      prdata,        // apb read data
   output logic             pslverr,       // apb error
   input  wire logic        tx_bit_req,    // pin: transmit bit time, level toggles
   input  wire logic [7:0]  tx_bitpos,     // transmit bit position, steady
   input  wire logic        tx_data_in,    // framer transmit bit
   output logic             tx_data_out,   // transmit bit after insertion
   input  wire logic        rx_clk,        // pin: recovered receive clock
   input  wire logic [7:0]  rx_bitpos,     // receive bit position, steady
   input  wire logic        rx_data,       // received bit, pin
   input  wire logic        ebit_err,      // framer e-bit error strobe
   output logic             user_output_a, // user output a
   output logic             user_output_b, // user output b
   output logic             irq            // level interrupt
);
   // ---------------- synchronisers
   logic [1:0] txs_r, rxc_r, rxd_r;
   logic       txs_d_r, rxc_d_r, rxd_d_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txs_r   <= 2'h0;
         rxc_r   <= 2'h0;
         rxd_r   <= 2'h0;
         txs_d_r <= 1'b0;
         rxc_d_r <= 1'b0;
         rxd_d_r <= 1'b0;
      end else begin
         txs_r   <= {txs_r[0], tx_bit_req};
         rxc_r   <= {rxc_r[0], rx_clk};
         rxd_r   <= {rxd_r[0], rx_data};
         txs_d_r <= txs_r[1];
         rxc_d_r <= rxc_r[1];
         rxd_d_r <= rxd_r[1];
      end
   end
   wire tx_stb = txs_r[1] ^ txs_d_r;
   wire rx_stb = rxc_r[1] & ~rxc_d_r;
   wire rx_bit = rxd_d_r;

   // ---------------- registers
   logic [3:0]  mode_r;
   logic [4:0]  txsel_r, rxsel_r;
   logic [`PRBS_IRQ_W-1:0] istat_r, imask_r;
   logic [3:0]  outcfg_r;
   logic [15:0] errcnt_r, ebitcnt_r;
   logic        locked_r;
   logic        tx_out_r;
   logic        pulse_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   logic        irq_r;
   logic        ua_r, ub_r;

   wire [1:0] tx_mode = mode_r[`PRBS_TXMODE_LSB+1:`PRBS_TXMODE_LSB];
   wire [1:0] rx_mode = mode_r[`PRBS_RXMODE_LSB+1:`PRBS_RXMODE_LSB];

   wire setup   = psel & ~penable;
   wire wr_acc  = psel & penable & pwrite & pready_r;
   wire rd_acc  = psel & penable & ~pwrite & pready_r;
   wire a_mode  = paddr == `PRBS_OFF_MODE;
   wire a_txs   = paddr == `PRBS_OFF_TXSEL;
   wire a_rxs   = paddr == `PRBS_OFF_RXSEL;
   wire a_stat  = paddr == `PRBS_OFF_STAT;
   wire a_err   = paddr == `PRBS_OFF_ERRCNT;
   wire a_ist   = paddr == `PRBS_OFF_IRQSTAT;
   wire a_imk   = paddr == `PRBS_OFF_IRQMASK;
   wire a_ocf   = paddr == `PRBS_OFF_OUTCFG;
   wire a_ebc   = paddr == `PRBS_OFF_EBITCNT;
   wire a_hit   = a_mode | a_txs | a_rxs | a_stat | a_err | a_ist | a_imk | a_ocf | a_ebc;
   wire [31:0] rd_mux =
      a_mode ? {28'h0, mode_r} :
      a_txs  ? {27'h0, txsel_r} :
      a_rxs  ? {27'h0, rxsel_r} :
      a_stat ? {31'h0, locked_r} :
      a_err  ? {16'h0, errcnt_r} :
      a_ist  ? {29'h0, istat_r} :
      a_imk  ? {29'h0, imask_r} :
      a_ocf  ? {28'h0, outcfg_r} :
      a_ebc  ? {16'h0, ebitcnt_r} : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= setup;
         pslverr_r <= setup & ~a_hit;
         if (setup & ~pwrite) begin
            prdata_r <= rd_mux;
         end
      end
   end
   assign pready  = pready_r;
   assign prdata  = prdata_r;
   assign pslverr = pslverr_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r   <= 4'h0;
         txsel_r  <= 5'h00;
         rxsel_r  <= 5'h00;
         imask_r  <= 3'h0;
         outcfg_r <= 4'h0;
      end else if (wr_acc) begin
         if (a_mode) mode_r   <= pwdata[3:0];
         if (a_txs)  txsel_r  <= pwdata[4:0];
         if (a_rxs)  rxsel_r  <= pwdata[4:0];
         if (a_imk)  imask_r  <= pwdata[2:0];
         if (a_ocf)  outcfg_r <= pwdata[3:0];
      end
   end

   // ---------------- transmit generator
   logic tx_use, tx_fb;
   prbs_slot_gate u_txgate (
      .mode    (tx_mode),
      .sel     (txsel_r),
      .bitpos  (tx_bitpos),
      .use_bit (tx_use)
   );
   prbs_lfsr u_txlfsr (
      .pclk     (pclk),
      .presetn  (presetn),
      .adv      (tx_stb & tx_use),
      .load     (1'b0),
      .load_bit (1'b0),
      .fb       (tx_fb),
      .state    ()
   );
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_out_r <= 1'b0;
      end else if (tx_stb) begin
         tx_out_r <= tx_use ? tx_fb : tx_data_in;
      end
   end
   assign tx_data_out = tx_out_r;

   // ---------------- receive checker
   logic rx_use, rx_fb;
   prbs_slot_gate u_rxgate (
      .mode    (rx_mode),
      .sel     (rxsel_r),
      .bitpos  (rx_bitpos),
      .use_bit (rx_use)
   );
   prbs_sync_type sync_r, sync_nxt;
   wire rx_adv  = rx_stb & rx_use;
   wire mism    = rx_bit ^ rx_fb;
   wire hunting = (sync_r == PRBS_HUNT);
   prbs_lfsr u_rxlfsr (
      .pclk     (pclk),
      .presetn  (presetn),
      .adv      (rx_adv),
      .load     (hunting),
      .load_bit (rx_bit),
      .fb       (rx_fb),
      .state    ()
   );
   logic [3:0] good_r;
   logic [5:0] win_r;
   logic [2:0] werr_r;
   wire bit_err  = rx_adv & mism & (sync_r == PRBS_LOCKED);
   wire win_end  = (win_r == 6'(`PRBS_WIN_BITS - 1));
   wire [2:0] werr_inc = werr_r + 3'(bit_err);
   wire lose     = bit_err & (werr_inc >= 3'(`PRBS_ERR_LIMIT));
   always_comb begin
      sync_nxt = sync_r;
      case (sync_r)
         PRBS_HUNT:   if (rx_adv && good_r == 4'(`PRBS_LOCK_GOOD - 1)) sync_nxt = PRBS_VERIFY;
         PRBS_VERIFY: if (rx_adv) sync_nxt = mism ? PRBS_HUNT : (good_r == 4'hF ? PRBS_LOCKED : PRBS_VERIFY);
         PRBS_LOCKED: if (lose) sync_nxt = PRBS_HUNT;
         default:     sync_nxt = PRBS_HUNT;
      endcase
      if (rx_mode == PRBS_OFF) sync_nxt = PRBS_HUNT;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_r <= PRBS_HUNT;
         good_r <= 4'h0;
         win_r  <= 6'h00;
         werr_r <= 3'h0;
      end else begin
         sync_r <= sync_nxt;
         if (sync_nxt != sync_r) good_r <= 4'h0;
         else if (rx_adv && sync_r != PRBS_LOCKED) good_r <= good_r + 4'h1;
         if (sync_r != PRBS_LOCKED || lose) begin
            win_r  <= 6'h00;
            werr_r <= 3'h0;
         end else if (rx_adv) begin
            win_r  <= win_end ? 6'h00 : win_r + 6'h01;
            werr_r <= win_end ? 3'h0 : werr_inc;
         end
      end
   end
   wire lock_now = (sync_r == PRBS_LOCKED);

   // ---------------- counters, pulses, interrupts
   wire rx_on = (rx_mode != PRBS_OFF);
   wire [2:0] ev = {bit_err, ~lock_now & (sync_nxt == PRBS_LOCKED), lose};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         locked_r  <= 1'b0;
         errcnt_r  <= 16'h0000;
         ebitcnt_r <= 16'h0000;
         istat_r   <= 3'h0;
         pulse_r   <= 1'b0;
         irq_r     <= 1'b0;
         ua_r      <= 1'b0;
         ub_r      <= 1'b0;
      end else begin
         locked_r <= lock_now;
         if (rx_on & bit_err & (errcnt_r != 16'hFFFF)) errcnt_r <= errcnt_r + 16'h0001;
         if (~rx_on & ebit_err & (ebitcnt_r != 16'hFFFF)) ebitcnt_r <= ebitcnt_r + 16'h0001;
         // set wins over write-one-to-clear
         istat_r <= (istat_r & ~((wr_acc & a_ist) ? pwdata[2:0] : 3'h0)) | ev;
         irq_r   <= |(istat_r & imask_r);
         // pulse held from the error bit edge until the next fall of rx_clk
         if (bit_err) pulse_r <= 1'b1;
         else if (~rxc_r[1]) pulse_r <= 1'b0;
         ua_r <= outcfg_r[0] ? pulse_r : outcfg_r[1];
         ub_r <= outcfg_r[2] ? pulse_r : outcfg_r[3];
      end
   end
   assign irq           = irq_r;
   assign user_output_a = ua_r;
   assign user_output_b = ub_r;
endmodule
`default_nettype wire

// >>> dv/ptgc_assertions.sv
// Purpose: port checker for the pattern test block
// Assumes: apb master keeps the setup then access order
// Notes: mode and output config bit 0 (user output a pulse select) are mirrored from apb writes
`timescale 1ns/1ns
`default_nettype none
module ptgc_assertions (
   input wire logic        pclk,          // clock
   input wire logic        presetn,       // reset, low
   input wire logic        psel,          // select
   input wire logic        penable,       // enable
   input wire logic        pwrite,        // direction
   input wire logic [11:0] paddr,         // address
   input wire logic [31:0] pwdata,        // write data
   input wire logic        pready,        // ready
   input wire logic [31:0] prdata,        // read data
   input wire logic        pslverr,       // error
   input wire logic        tx_bit_req,    // tx strobe
   input wire logic [7:0]  tx_bitpos,     // tx position
   input wire logic        tx_data_in,    // tx in
   input wire logic        tx_data_out,   // tx out
   input wire logic        rx_clk,        // rx clock
   input wire logic [7:0]  rx_bitpos,     // rx position
   input wire logic        rx_data,       // rx bit
   input wire logic        ebit_err,      // e-bit strobe
   input wire logic        user_output_a, // output a
   input wire logic        user_output_b, // output b
   input wire logic        irq            // interrupt
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [3:0] mode_r;
   logic       cfg_a_r;
   wire        wr_done = psel && penable && pready && pwrite;
   wire        rd_done = psel && penable && pready && !pwrite;
   wire [3:0]  mode_nxt = (wr_done && paddr == 12'h000) ? pwdata[3:0] : mode_r;
   wire        cfg_a_nxt = (wr_done && paddr == 12'h01C) ? pwdata[0] : cfg_a_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= 4'h0;
         cfg_a_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         cfg_a_r <= cfg_a_nxt;
      end
   end
   AST_PREADY_SETUP: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   AST_PREADY_ONE: assert property (pready |=> !pready)
      else $error("ready held too long");
   AST_SLVERR_ADDR: assert property (pready && paddr > 12'h020 |-> pslverr)
      else $error("unmapped access not refused");
   AST_SLVERR_RD0: assert property (rd_done && pslverr |-> prdata == 32'h0000_0000)
      else $error("refused read not zero");
   AST_MODE_RB: assert property (rd_done && paddr == 12'h000 |-> prdata == {28'h000_0000, mode_r})
      else $error("mode readback wrong");
   AST_LOCK_FIELD: assert property (rd_done && paddr == 12'h00C |-> prdata[31:1] == 31'h0000_0000)
      else $error("status upper bits set");
   AST_COUNT_WIDTH: assert property (rd_done && paddr == 12'h010 |-> prdata[31:16] == 16'h0000)
      else $error("error count wider than 16 bits");
   AST_PULSE_END: assert property (user_output_a && cfg_a_r |-> ##[1:30] !user_output_a)
      else $error("error pulse too long");
   AST_PULSE_RXHIGH: assert property ($rose(user_output_a) && cfg_a_r |-> $past(rx_clk, 3))
      else $error("error pulse not aligned to rx clock");
   cover property (wr_done && paddr == 12'h000);
   cover property ($rose(user_output_a));
   cover property (pready && pslverr);
endmodule
bind prbs_test_top ptgc_assertions ptgc_assertions_inst (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .tx_bit_req, .tx_bitpos, .tx_data_in,
   .tx_data_out, .rx_clk, .rx_bitpos, .rx_data, .ebit_err, .user_output_a, .user_output_b, .irq);
`default_nettype wire

// >>> dv/ptgc_far_end.sv
// Purpose: far-end line equipment sending the test pattern
// Assumes: recovered clock period of 24 system clocks
// Notes: flip inverts every bit sent while high
`timescale 1ns/1ns
`default_nettype none
module ptgc_far_end (
   input  wire logic       pclk,      // system clock
   input  wire logic       presetn,   // reset, low
   input  wire logic       flip,      // corrupt bits
   output logic            rx_clk,    // recovered clock
   output logic [7:0]      rx_bitpos, // frame position
   output logic            rx_data    // line bit
);
   logic [14:0] lfsr_r;
   logic [4:0]  cnt_r;
   wire         nb = lfsr_r[14] ^ lfsr_r[13];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lfsr_r <= 15'h7FFF;
         cnt_r <= 5'h00;
         rx_clk <= 1'b0;
         rx_bitpos <= 8'hFF;
         rx_data <= 1'b0;
      end else begin
         cnt_r <= (cnt_r == 5'h17) ? 5'h00 : cnt_r + 5'h01;
         if (cnt_r == 5'h00) begin
            lfsr_r <= {lfsr_r[13:0], nb};
            rx_data <= nb ^ flip;
            rx_bitpos <= rx_bitpos + 8'h01;
            rx_clk <= 1'b0;
         end
         if (cnt_r == 5'h0C) rx_clk <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// >>> dv/prbs_test_generator_checker_tb_top.sv
// Purpose: self-checking bench for the pattern test block
// Assumes: far end sends the pattern in every frame bit
// Notes: an irq mask bit set lets that event drive irq
`timescale 1ns/1ns
`default_nettype none
module prbs_test_generator_checker_tb_top
   import prbs_pkg::*;
;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        tx_bit_req = 1'b0, tx_data_in = 1'b1, ebit_err = 1'b0, flip = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [7:0]  tx_bitpos = 8'h00;
   logic [31:0] prdata, q;
   logic [7:0]  rx_bitpos;
   logic        pready, pslverr, tx_data_out, rx_clk, rx_data, user_output_a, user_output_b, irq;
   int          n_errors = 0, n_compared = 0, cyc = 0, pulses = 0;
   prbs_test_top prbs_test_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr, .tx_bit_req, .tx_bitpos, .tx_data_in, .tx_data_out, .rx_clk,
      .rx_bitpos, .rx_data, .ebit_err, .user_output_a, .user_output_b, .irq);
   ptgc_far_end ptgc_far_end_inst (.pclk, .presetn, .flip, .rx_clk, .rx_bitpos, .rx_data);
   always #4 pclk = ~pclk;
   always @(posedge user_output_a) pulses++;
   task automatic results;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         results();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(q, e);
   endtask
   task automatic tx_step(input logic [7:0] pos, input logic e);
      tx_bitpos <= pos;
      repeat (2) @(posedge pclk);
      tx_bit_req <= ~tx_bit_req;
      repeat (8) @(posedge pclk);
      chk(32'(tx_data_out), 32'(e));
   endtask
   task automatic ebit(input logic [31:0] e);
      ebit_err <= 1'b1;
      @(posedge pclk);
      ebit_err <= 1'b0;
      rd(12'h020, e);
   endtask
   task automatic hit(input int n);
      @(negedge rx_clk);
      @(posedge pclk);
      flip <= 1'b1;
      repeat (n) @(negedge rx_clk);
      @(posedge pclk);
      flip <= 1'b0;
      repeat (100) @(posedge pclk);
   endtask
   task automatic irq_is(input logic e);
      repeat (3) @(posedge pclk);
      chk(32'(irq), 32'(e));
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(12'h000, 32'h0000_0000);
      ebit(32'h0000_0001);
      apb(1'b1, 12'h004, 32'h0000_0005);
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, 12'h000, 32'(m * 4 + PRBS_ALL));
         tx_step(8'h00, m != PRBS_ALL);
         tx_step(8'h28, m == PRBS_OFF);
      end
      ebit(32'h0000_0001);
      q = 32'h0000_0000;
      for (int i = 0; i < 100 && q[0] !== 1'b1; i++) begin
         repeat (20) @(posedge pclk);
         apb(1'b0, 12'h00C, 32'h0000_0000);
      end
      chk(q, 32'h0000_0001);
      apb(1'b1, 12'h01C, 32'h0000_0001);
      apb(1'b1, 12'h014, 32'h0000_0007);
      apb(1'b1, 12'h018, 32'h0000_0007);
      hit(1);
      rd(12'h010, 32'h0000_0001);
      chk(32'(pulses), 32'h0000_0001);
      rd(12'h00C, 32'h0000_0001);
      rd(12'h014, 32'h0000_0004);
      irq_is(1'b1);
      apb(1'b1, 12'h018, 32'h0000_0000);
      irq_is(1'b0);
      apb(1'b1, 12'h018, 32'h0000_0007);
      apb(1'b1, 12'h014, 32'h0000_0004);
      irq_is(1'b0);
      // twelve flips put at least six errors inside one fixed 64-bit window
      hit(12);
      rd(12'h00C, 32'h0000_0000);
      chk(q & 32'h0000_0001, 32'h0000_0000);
      apb(1'b0, 12'h014, 32'h0000_0000);
      chk(q & 32'h0000_0001, 32'h0000_0001);
      rd(12'h040, 32'h0000_0000);
      apb(1'b1, 12'h01C, 32'h0000_0008);
      repeat (3) @(posedge pclk);
      chk({30'h0, user_output_b, user_output_a}, 32'h0000_0002);
      results();
   end
endmodule
`default_nettype wire
